// [hdl/cpo_pkg.sv]
/*
 * Constants and carrier types for the eight-channel PWM output block.
 * Assumes a 200 MHz clock and commands already decoded from CAN frames.
 */
package cpo_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CPO_CLK_HZ       = 200_000_000;
    localparam int unsigned CPO_WDOG_TIME_MS = 1000;
    localparam int unsigned CPO_WDOG_CYCLES  = (CPO_CLK_HZ / 1000) * CPO_WDOG_TIME_MS;

    // ************************************************************
    // Channel layout and ranges
    // ************************************************************
    localparam int unsigned CPO_NUM_CHAN  = 8;
    localparam int unsigned CPO_CHAN_W    = 3;
    localparam int unsigned CPO_DUTY_W    = 8;
    localparam int unsigned CPO_FREQ_W    = 13;
    localparam int unsigned CPO_ACC_W     = 28;
    localparam int unsigned CPO_PROD_W    = 36;
    localparam logic [7:0]  CPO_ODD_STEPS = 8'hff;
    localparam logic [7:0]  CPO_EVEN_STEPS = 8'h14;
    localparam logic [12:0] CPO_ODD_FMIN  = 13'h0008;
    localparam logic [12:0] CPO_ODD_FMAX  = 13'h1388;
    localparam logic [12:0] CPO_EVEN_FMIN = 13'h0001;
    localparam logic [12:0] CPO_EVEN_FMAX = 13'h0064;
    localparam logic [27:0] CPO_ACC_FULL  = 28'hbebc200;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [CPO_CHAN_W-1:0] chan;
        logic [CPO_DUTY_W-1:0] duty;
        logic [CPO_FREQ_W-1:0] freq_hz;
    } cpo_cmd_t;

    typedef struct packed {
        logic [CPO_DUTY_W-1:0] duty;
        logic [CPO_FREQ_W-1:0] freq_hz;
    } cpo_set_t;

endpackage

// [hdl/cpo_pwm_outputs.sv]
/*
 * Eight PWM outputs with push-pull drive, commanded per channel over CAN.
 * Assumes a frame decoder upstream that pulses can_msg_i per received
 * frame and cmd_valid_i with cmd_i per duty/frequency command.
 */
`timescale 1ns/1ps
`default_nettype none

module cpo_pwm_outputs
    import cpo_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = CPO_WDOG_CYCLES
)
(
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // CAN traffic and commands
    input  wire logic                    can_msg_i,
    input  wire logic                    cmd_valid_i,
    input  wire cpo_cmd_t                cmd_i,
    // Output drivers
    output logic [CPO_NUM_CHAN-1:0]      drive_high_o,
    output logic [CPO_NUM_CHAN-1:0]      drive_low_o,
    output logic                         outputs_enabled_o
);

    // ************************************************************
    // Link watchdog
    // ************************************************************
    logic        enabled_r;
    logic        enabled_nxt;
    logic [31:0] wdog_r;
    logic [31:0] wdog_nxt;
    wire         traffic  = can_msg_i | cmd_valid_i;
    wire         wdog_end = (wdog_r >= WDOG_CYCLES - 1);

    always_comb
    begin
        enabled_nxt = enabled_r;
        wdog_nxt    = wdog_r;
        if (traffic)
        begin
            enabled_nxt = 1'b1;
            wdog_nxt    = '0;
        end
        else if (enabled_r)
        begin
            if (wdog_end)
            begin
                enabled_nxt = 1'b0;
                wdog_nxt    = '0;
            end
            else
            begin
                wdog_nxt = wdog_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            enabled_r <= 1'b0;
            wdog_r    <= '0;
        end
        else
        begin
            enabled_r <= enabled_nxt;
            wdog_r    <= wdog_nxt;
        end
    end

    assign outputs_enabled_o = enabled_r;

    // ************************************************************
    // Per-channel generators
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < CPO_NUM_CHAN; g = g + 1)
        begin : gen_chan
            // Index 0 is the first output, so even indices are the odd group
            localparam logic       IS_ODD = ((g % 2) == 0);
            localparam logic [7:0] STEPS  = IS_ODD ? CPO_ODD_STEPS : CPO_EVEN_STEPS;
            localparam logic [12:0] FMIN  = IS_ODD ? CPO_ODD_FMIN : CPO_EVEN_FMIN;
            localparam logic [12:0] FMAX  = IS_ODD ? CPO_ODD_FMAX : CPO_EVEN_FMAX;

            cpo_set_t        pend_r;
            cpo_set_t        pend_nxt;
            cpo_set_t        act_r;
            cpo_set_t        act_nxt;
            logic [27:0]     acc_r;
            logic [27:0]     acc_nxt;
            logic            low_r;
            logic            low_nxt;

            wire             hit       = cmd_valid_i && (cmd_i.chan == CPO_CHAN_W'(g));
            wire [7:0]       duty_clip = (cmd_i.duty > STEPS) ? STEPS : cmd_i.duty;
            wire [12:0]      freq_clip = (cmd_i.freq_hz == '0)  ? '0   :
                                         (cmd_i.freq_hz < FMIN) ? FMIN :
                                         (cmd_i.freq_hz > FMAX) ? FMAX :
                                         cmd_i.freq_hz;
            wire             is_static = (act_r.freq_hz == '0);
            wire [28:0]      acc_sum   = {1'b0, acc_r} + {16'h0, act_r.freq_hz};
            wire             wrap      = !is_static && (acc_sum >= {1'b0, CPO_ACC_FULL});
            wire [35:0]      pos_sc    = acc_r * STEPS;
            wire [35:0]      thr_sc    = act_r.duty * CPO_ACC_FULL;
            wire             pwm_low   = (pos_sc < thr_sc);
            wire             stat_low  = (act_r.duty != '0);

            always_comb
            begin
                pend_nxt = pend_r;
                if (hit)
                begin
                    pend_nxt.duty    = duty_clip;
                    pend_nxt.freq_hz = freq_clip;
                end
                act_nxt = act_r;
                acc_nxt = acc_r;
                if (!enabled_r)
                begin
                    act_nxt = pend_nxt;
                    acc_nxt = '0;
                end
                else if (is_static || wrap)
                begin
                    act_nxt = pend_nxt;
                    acc_nxt = '0;
                    if (wrap)
                    begin
                        acc_nxt = acc_sum[27:0] - CPO_ACC_FULL;
                    end
                end
                else
                begin
                    acc_nxt = acc_sum[27:0];
                end
                low_nxt = is_static ? stat_low : pwm_low;
            end

            always_ff @(posedge clock_i)
            begin
                if (reset_i)
                begin
                    pend_r <= '0;
                    act_r  <= '0;
                    acc_r  <= '0;
                    low_r  <= 1'b0;
                end
                else
                begin
                    pend_r <= pend_nxt;
                    act_r  <= act_nxt;
                    acc_r  <= acc_nxt;
                    low_r  <= low_nxt;
                end
            end

            // Push-pull drive, both off while disabled
            assign drive_low_o[g]  = enabled_r && low_r;
            assign drive_high_o[g] = enabled_r && !low_r;
        end
    endgenerate

endmodule

`default_nettype wire

// [verification/cpo_pwm_outputs_properties.sv]
/* Checker for the PWM output block.
   Sees only the top ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module cpo_pwm_outputs_properties
    import cpo_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = CPO_WDOG_CYCLES
)
(
    // Inputs of the block
    input wire logic                   clock_i,
    input wire logic                   reset_i,
    input wire logic                   can_msg_i,
    input wire logic                   cmd_valid_i,
    input wire cpo_cmd_t               cmd_i,
    // Outputs of the block
    input wire logic [CPO_NUM_CHAN-1:0] drive_high_o,
    input wire logic [CPO_NUM_CHAN-1:0] drive_low_o,
    input wire logic                   outputs_enabled_o
);
    // ****
    // Helpers
    // ****
    logic [31:0] idle_r;
    logic        pwm0_r;
    wire logic   traffic = can_msg_i | cmd_valid_i;
    always_ff @(posedge clock_i)
    begin
        idle_r <= (reset_i) ? '1 : (traffic) ? '0 : idle_r + {31'h0, idle_r != '1};
        pwm0_r <= !reset_i && (pwm0_r || (cmd_valid_i && cmd_i.chan == 3'h0
            && cmd_i.freq_hz != 13'h0));
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_never_both: assert property (!(|(drive_high_o & drive_low_o)))
        else $error("both drivers on");
    a_off_no_drive: assert property (!outputs_enabled_o |-> (drive_high_o | drive_low_o) == 8'h00)
        else $error("drive while disabled");
    a_on_one_side: assert property (outputs_enabled_o |-> (drive_high_o | drive_low_o) == 8'hff)
        else $error("output floats while enabled");
    a_traffic_enables: assert property (traffic |=> outputs_enabled_o)
        else $error("traffic did not enable");
    a_idle_stays_off: assert property (!outputs_enabled_o && !traffic |=> !outputs_enabled_o)
        else $error("enabled without traffic");
    a_wdog_expires: assert property (idle_r >= WDOG_CYCLES |-> !outputs_enabled_o)
        else $error("still enabled after timeout");
    a_wdog_holds: assert property (idle_r < WDOG_CYCLES - 2 |=> outputs_enabled_o)
        else $error("disabled too early");
    a_static_switch: assert property (
        cmd_valid_i && cmd_i.chan == 3'h0 && cmd_i.freq_hz == 13'h0 && !pwm0_r
        && outputs_enabled_o |-> ##2 drive_low_o[0] == ($past(cmd_i.duty, 2) != 8'h0))
        else $error("static output wrong");
    c_enable: cover property ($rose(outputs_enabled_o));
    c_expire: cover property ($fell(outputs_enabled_o));
    c_low: cover property (drive_low_o[0]);
endmodule
bind cpo_pwm_outputs cpo_pwm_outputs_properties #(.WDOG_CYCLES(WDOG_CYCLES)) cpo_props_i
    (.clock_i, .reset_i, .can_msg_i, .cmd_valid_i, .cmd_i, .drive_high_o, .drive_low_o,
     .outputs_enabled_o);
`default_nettype wire

// [verification/cpo_host_model.sv]
/* Host that sends commands and traffic.
   Drives at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module cpo_host_model
    import cpo_pkg::*;
(
    // Clock
    input  wire logic clock_i,
    // Toward the block
    output logic      can_msg_o = 1'b0,
    output logic      cmd_valid_o = 1'b0,
    output cpo_cmd_t  cmd_o = '0
);
    task send(input logic [2:0] c, input logic [7:0] d, input logic [12:0] f);
        @(negedge clock_i);
        cmd_o = {c, d, f};
        cmd_valid_o = 1'b1;
        @(negedge clock_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
    endtask
    task ping();
        @(negedge clock_i);
        can_msg_o = 1'b1;
        @(negedge clock_i);
        can_msg_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verification/cpo_pwm_outputs_tb.sv]
/* Testbench for the PWM output block.
   Uses a short watchdog count of 200 cycles. */
`timescale 1ns/1ps
`default_nettype none
module cpo_pwm_outputs_tb;
    import cpo_pkg::*;
    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    wire logic  can_msg;
    wire logic  cmd_valid;
    wire cpo_cmd_t cmd;
    logic [7:0] dh;
    logic [7:0] dl;
    logic       en;
    int         errors = 0;
    int         samples_checked = 0;
    always #2.5 clock_i = ~clock_i;
    cpo_host_model cpo_host_model_i (.clock_i, .can_msg_o(can_msg), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd));
    cpo_pwm_outputs #(.WDOG_CYCLES(200)) cpo_pwm_outputs_i (.clock_i, .reset_i,
        .can_msg_i(can_msg), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .drive_high_o(dh),
        .drive_low_o(dl), .outputs_enabled_o(en));
    task check(input logic [16:0] exp, input string m);
        samples_checked++;
        if ({en, dh, dl} !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task conclude();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task t_static();
        logic [2:0] ch[4]  = '{3'h0, 3'h1, 3'h0, 3'h7};
        logic [7:0] du[4]  = '{8'hff, 8'h14, 8'h00, 8'h01};
        logic [7:0] low[4] = '{8'h01, 8'h03, 8'h02, 8'h82};
        repeat (5) @(negedge clock_i);
        check(17'h0, "output before traffic");
        for (int i = 0; i < 4; i++)
        begin
            cpo_host_model_i.send(ch[i], du[i], 13'h0);
            repeat (2) @(negedge clock_i);
            check({1'b1, ~low[i], low[i]}, "static level");
        end
    endtask
    task t_watchdog();
        repeat (190) @(negedge clock_i);
        check({1'b1, 8'h7d, 8'h82}, "dropped early");
        repeat (15) @(negedge clock_i);
        check(17'h0, "no timeout");
        cpo_host_model_i.ping();
        check({1'b1, 8'h7d, 8'h82}, "not re-enabled");
    endtask
    initial
    begin
        repeat (10) @(negedge clock_i);
        reset_i = 1'b0;
        t_static();
        t_watchdog();
        conclude();
    end
    initial
    begin
        #5000;
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
